// ---- smcg_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module smcg_bench;
   import smcg_pkg::*;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic       slp = 1'b0;
   logic [4:0] wk = 5'h00;
   logic [7:0] rdata;
   logic [7:0] pce;
   logic       cpu, omain, oxtal, rtc, sys, asleep;
   logic [4:0] g;
   int         num_errors = 0;
   int         compares = 0;
   // per mode: legal wake used, a refused wake (-1 none), gate image and mask
   smcg_mode_e modes [5] = '{SMCG_IDLE, SMCG_PDOWN, SMCG_PSAVE, SMCG_STBY, SMCG_XSTBY};
   int         good [5] = '{4, 0, 3, 1, 2};
   int         bad [5] = '{-1, 3, 4, 3, 4};
   logic [4:0] ge [5] = '{5'h0F, 5'h00, 5'h02, 5'h04, 5'h0A};
   // crystal in extended standby left open: cpu, main osc, rtc and sys are pinned
   logic [4:0] gm [5] = '{5'h1F, 5'h1F, 5'h1F, 5'h1F, 5'h1B};

   always #5 clk = ~clk;
   assign g = {cpu, omain, oxtal, rtc, sys};

   smcg_top u_smcg_top (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .sleep_req(slp), .wake_two_wire_serial_port(wk[0]),
      .wake_usb_resume(wk[1]), .wake_pin_change(wk[2]), .wake_counter(wk[3]),
      .wake_irq(wk[4]), .cpu_clk_en(cpu), .osc_main_en(omain), .osc_xtal_en(oxtal),
      .rtc_clk_en(rtc), .sys_clk_en(sys), .periph_clk_en(pce), .asleep(asleep));

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wreg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rchk(input string nm, input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(nm, rdata, exp);
   endtask

   task automatic sleep_now;
      @(posedge clk);
      slp <= 1'b1;
      @(posedge clk);
      slp <= 1'b0;
      @(negedge clk);
   endtask

   task automatic conclude;
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      #100000;
      num_errors++;
      conclude();
   end

   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      chk("reset gates", {2'h0, asleep, g}, 8'h1F);
      rchk("ctrl rst", SMCG_A_CTRL, SMCG_CTRL_RST);
      rchk("prr rst", SMCG_A_PRR, SMCG_PRR_RST);
      wreg(3'h7, 8'hFF);
      rchk("unmapped", 3'h7, 8'h00);
      wreg(SMCG_A_CTRL, 8'h0E);
      rchk("ctrl rw", SMCG_A_CTRL, 8'h0E);
      wreg(SMCG_A_PRR, 8'hA5);
      // the peripheral gates follow the stored mask one cycle later
      repeat (2) @(negedge clk);
      chk("periph active", pce, 8'h5A);
      rchk("prr rw", SMCG_A_PRR, 8'hA5);
      $display("test registers done");
      // disabled sleep, then an unused mode code
      for (int k = 0; k < 2; k++) begin
         wreg(SMCG_A_CTRL, (k == 0) ? 8'h04 : 8'h03);
         sleep_now();
         chk("refused sleep", {2'h0, asleep, g}, 8'h1F);
      end
      $display("test refusals done");
      for (int i = 0; i < 5; i++) begin
         wreg(SMCG_A_CTRL, {4'h0, modes[i], 1'b1});
         sleep_now();
         chk("asleep", {7'h0, asleep}, 8'h01);
         chk("gates", {3'h0, g & gm[i]}, {3'h0, ge[i] & gm[i]});
         chk("periph", pce, (i == 0) ? 8'h5A : 8'h00);
         // the cause of the previous wake is still held beside the sleep bit
         rchk("status", SMCG_A_STATUS,
              (i == 0) ? 8'h01 : (8'h01 | (8'h02 << good[i - 1])));
         if (bad[i] >= 0) begin
            @(posedge clk);
            wk[bad[i]] <= 1'b1;
            repeat (3) @(posedge clk);
            wk <= 5'h00;
            @(negedge clk);
            chk("wrong wake", {7'h0, asleep}, 8'h01);
         end
         @(posedge clk);
         wk[good[i]] <= 1'b1;
         @(posedge clk);
         wk <= 5'h00;
         @(negedge clk);
         chk("awake", {2'h0, asleep, g}, 8'h1F);
         rchk("cause", SMCG_A_STATUS, 8'h01 << (good[i] + 1));
      end
      $display("test modes done");
      wreg(SMCG_A_CTRL, 8'h05);
      sleep_now();
      @(posedge clk);
      rst <= 1'b1;
      @(negedge clk);
      chk("reset wake", {2'h0, asleep, g}, 8'h1F);
      @(posedge clk);
      rst <= 1'b0;
      rchk("ctrl after rst", SMCG_A_CTRL, SMCG_CTRL_RST);
      $display("test reset wake done");
      conclude();
   end
endmodule // smcg_bench
`default_nettype wire

// ---- smcg_pkg.sv ----
package smcg_pkg;
   typedef enum logic [2:0] {
      SMCG_IDLE  = 3'h0,
      SMCG_PDOWN = 3'h2,
      SMCG_PSAVE = 3'h3,
      SMCG_STBY  = 3'h6,
      SMCG_XSTBY = 3'h7
   } smcg_mode_e;

   localparam int         SMCG_NPERIPH   = 8;
   localparam logic [2:0] SMCG_ADDR_W    = 3'h3;
   localparam logic [2:0] SMCG_A_CTRL    = 3'h0;
   localparam logic [2:0] SMCG_A_PRR     = 3'h1;
   localparam logic [2:0] SMCG_A_STATUS  = 3'h2;
   localparam int         SMCG_CTRL_EN   = 0;
   localparam int         SMCG_CTRL_MLO  = 1;
   localparam int         SMCG_CTRL_MHI  = 3;
   localparam logic [7:0] SMCG_CTRL_RST  = 8'h00;
   localparam logic [7:0] SMCG_PRR_RST   = 8'h00;
   localparam int         SMCG_ST_SLEEP  = 0;
   localparam int         SMCG_ST_WLO    = 1;
   localparam int         SMCG_ST_WHI    = 5;
   localparam int         SMCG_NWAKE     = 5;
   localparam int         SMCG_W_TWOWIRE = 0;
   localparam int         SMCG_W_USB     = 1;
   localparam int         SMCG_W_PIN     = 2;
   localparam int         SMCG_W_CNT     = 3;
   localparam int         SMCG_W_IRQ     = 4;
endpackage

// ---- smcg_sync_stage.sv ----
`timescale 1ns/1ns
`default_nettype none
// registered clock-gate enable, one per domain
module smcg_sync_stage (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic en_d,
   output var  logic en_q
);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         en_q <= 1'b1;
      end else begin
         en_q <= en_d;
      end
   end
endmodule // smcg_sync_stage
`default_nettype wire

// ---- smcg_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module smcg_top
   import smcg_pkg::*;
#(
   parameter int NPERIPH = smcg_pkg::SMCG_NPERIPH
) (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic [2:0]         addr,
   input  wire logic [7:0]         wdata,
   input  wire logic               wr,
   input  wire logic               rd,
   output var  logic [7:0]         rdata,
   input  wire logic               sleep_req,
   input  wire logic               wake_two_wire_serial_port,
   input  wire logic               wake_usb_resume,
   input  wire logic               wake_pin_change,
   input  wire logic               wake_counter,
   input  wire logic               wake_irq,
   output var  logic               cpu_clk_en,
   output var  logic               osc_main_en,
   output var  logic               osc_xtal_en,
   output var  logic               rtc_clk_en,
   output var  logic               sys_clk_en,
   output var  logic [NPERIPH-1:0] periph_clk_en,
   output var  logic               asleep
);
   import smcg_pkg::*;

   typedef enum logic {SMCG_ACTIVE, SMCG_SLEEPING} smcg_state_e;

   smcg_state_e        state_q, state_d;
   logic [7:0]         ctrl_q, ctrl_d;
   logic [7:0]         prr_q, prr_d;
   logic [7:0]         rdata_d;
   logic [SMCG_NWAKE-1:0] wlast_q, wlast_d;
   smcg_mode_e         mode_q, mode_d;
   smcg_mode_e         sel_mode;
   logic               legal;
   logic [SMCG_NWAKE-1:0] wvec;
   logic [SMCG_NWAKE-1:0] wallow;
   logic               wake;
   logic               cpu_d, main_d, xtal_d, rtc_d, sys_d;
   logic [NPERIPH-1:0] per_d;

   assign wvec = {wake_irq, wake_counter, wake_pin_change, wake_usb_resume,
                  wake_two_wire_serial_port};

   always_comb begin
      sel_mode = smcg_mode_e'(ctrl_q[SMCG_CTRL_MHI:SMCG_CTRL_MLO]);
      legal = 1'b0;
      unique case (ctrl_q[SMCG_CTRL_MHI:SMCG_CTRL_MLO])
         SMCG_IDLE, SMCG_PDOWN, SMCG_PSAVE, SMCG_STBY, SMCG_XSTBY: legal = 1'b1;
         default: legal = 1'b0;
      endcase
   end

   // wake sources allowed per mode
   always_comb begin
      wallow = '0;
      wallow[SMCG_W_TWOWIRE] = 1'b1;
      wallow[SMCG_W_USB]     = 1'b1;
      wallow[SMCG_W_PIN]     = 1'b1;
      unique case (mode_q)
         SMCG_IDLE: wallow = '1;
         SMCG_PDOWN: wallow[SMCG_W_CNT] = 1'b0;
         SMCG_PSAVE, SMCG_XSTBY: wallow[SMCG_W_CNT] = 1'b1;
         SMCG_STBY: wallow[SMCG_W_CNT] = 1'b0;
      endcase
   end
   assign wake = |(wvec & wallow);

   always_comb begin
      state_d = state_q;
      mode_d  = mode_q;
      ctrl_d  = ctrl_q;
      prr_d   = prr_q;
      wlast_d = wlast_q;
      rdata_d = 8'h00;
      if (wr && addr == SMCG_A_CTRL) begin
         // bits above the mode field stay at their reset value
         ctrl_d = SMCG_CTRL_RST;
         ctrl_d[SMCG_CTRL_MHI:SMCG_CTRL_EN] = wdata[SMCG_CTRL_MHI:SMCG_CTRL_EN];
      end
      // a new mask reaches the peripheral gates one cycle after the write
      if (wr && addr == SMCG_A_PRR) begin
         prr_d = wdata;
      end
      if (rd) begin
         unique case (addr)
            SMCG_A_CTRL:   rdata_d = ctrl_q;
            SMCG_A_PRR:    rdata_d = prr_q;
            SMCG_A_STATUS: rdata_d = {2'h0, wlast_q, state_q == SMCG_SLEEPING};
            default:       rdata_d = 8'h00;
         endcase
      end
      unique case (state_q)
         SMCG_ACTIVE: begin
            if (sleep_req && ctrl_q[SMCG_CTRL_EN] && legal) begin
               state_d = SMCG_SLEEPING;
               mode_d  = sel_mode;
            end
         end
         SMCG_SLEEPING: begin
            if (wake) begin
               state_d = SMCG_ACTIVE;
               wlast_d = wvec & wallow;
            end
         end
      endcase
   end

   // clock gate decisions
   always_comb begin
      cpu_d  = 1'b1;
      main_d = 1'b1;
      xtal_d = 1'b1;
      rtc_d  = 1'b1;
      sys_d  = 1'b1;
      per_d  = ~prr_q[NPERIPH-1:0];
      if (state_d == SMCG_SLEEPING) begin
         cpu_d = 1'b0;
         unique case (mode_d)
            SMCG_IDLE: ;
            SMCG_PDOWN: begin
               {main_d, xtal_d, rtc_d, sys_d} = 4'h0;
               per_d = '0;
            end
            SMCG_PSAVE: begin
               {main_d, xtal_d, sys_d} = 3'h0;
               per_d = '0;
            end
            SMCG_STBY: begin
               {main_d, rtc_d, sys_d} = 3'h0;
               per_d = '0;
            end
            SMCG_XSTBY: begin
               {xtal_d, sys_d} = 2'h0;
               per_d = '0;
            end
         endcase
      end
   end

   // one register per gate so no enable can glitch while a clock runs
   smcg_sync_stage u_cpu (
      .clk  (clk),
      .rst  (rst),
      .en_d (cpu_d),
      .en_q (cpu_clk_en)
   );
   smcg_sync_stage u_main (
      .clk  (clk),
      .rst  (rst),
      .en_d (main_d),
      .en_q (osc_main_en)
   );
   smcg_sync_stage u_xtal (
      .clk  (clk),
      .rst  (rst),
      .en_d (xtal_d),
      .en_q (osc_xtal_en)
   );
   smcg_sync_stage u_rtc (
      .clk  (clk),
      .rst  (rst),
      .en_d (rtc_d),
      .en_q (rtc_clk_en)
   );
   smcg_sync_stage u_sys (
      .clk  (clk),
      .rst  (rst),
      .en_d (sys_d),
      .en_q (sys_clk_en)
   );
   for (genvar g = 0; g < NPERIPH; g++) begin : g_per
      smcg_sync_stage u_p (
         .clk  (clk),
         .rst  (rst),
         .en_d (per_d[g]),
         .en_q (periph_clk_en[g])
      );
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= SMCG_ACTIVE;
         mode_q  <= SMCG_IDLE;
         ctrl_q  <= SMCG_CTRL_RST;
         prr_q   <= SMCG_PRR_RST;
         wlast_q <= '0;
         rdata   <= 8'h00;
         asleep  <= 1'b0;
      end else begin
         state_q <= state_d;
         mode_q  <= mode_d;
         ctrl_q  <= ctrl_d;
         prr_q   <= prr_d;
         wlast_q <= wlast_d;
         rdata   <= rdata_d;
         asleep  <= state_d == SMCG_SLEEPING;
      end
   end

   property p_pdown_all_off;
      @(posedge clk) disable iff (rst)
         (asleep && mode_q == SMCG_PDOWN) |-> !osc_main_en && !osc_xtal_en && !rtc_clk_en;
   endproperty
   a_pdown_all_off: assert property (p_pdown_all_off) else $error("pdown clock on");
   property p_idle_only_cpu;
      @(posedge clk) disable iff (rst)
         (asleep && mode_q == SMCG_IDLE) |-> !cpu_clk_en && sys_clk_en && osc_main_en;
   endproperty
   a_idle_only_cpu: assert property (p_idle_only_cpu) else $error("idle gating wrong");
   property p_psave_rtc;
      @(posedge clk) disable iff (rst)
         (asleep && mode_q == SMCG_PSAVE) |-> rtc_clk_en && !sys_clk_en;
   endproperty
   a_psave_rtc: assert property (p_psave_rtc) else $error("psave rtc stopped");
   property p_stby_xtal;
      @(posedge clk) disable iff (rst)
         (asleep && mode_q == SMCG_STBY) |-> osc_xtal_en && !rtc_clk_en;
   endproperty
   a_stby_xtal: assert property (p_stby_xtal) else $error("standby xtal off");
   property p_xstby;
      @(posedge clk) disable iff (rst)
         (asleep && mode_q == SMCG_XSTBY) |-> osc_main_en && rtc_clk_en && !sys_clk_en;
   endproperty
   a_xstby: assert property (p_xstby) else $error("ext standby wrong");
   property p_pdown_nowake_cnt;
      @(posedge clk) disable iff (rst)
         (asleep && mode_q == SMCG_PDOWN && !(|wvec[SMCG_W_PIN:SMCG_W_TWOWIRE]))
            |=> asleep;
   endproperty
   a_pdown_nowake_cnt: assert property (p_pdown_nowake_cnt) else $error("bad wake");
   property p_wake_restore;
      @(posedge clk) disable iff (rst)
         (asleep && wake_pin_change) |=> !asleep && cpu_clk_en && sys_clk_en;
   endproperty
   a_wake_restore: assert property (p_wake_restore) else $error("wake failed");
   property p_cnt_wake;
      @(posedge clk) disable iff (rst)
         (asleep && mode_q == SMCG_PSAVE && wake_counter) |=> !asleep;
   endproperty
   a_cnt_wake: assert property (p_cnt_wake) else $error("counter wake missed");
   property p_prr;
      @(posedge clk) disable iff (rst)
         (!asleep && !sleep_req) |=> periph_clk_en == ~$past(prr_q[NPERIPH-1:0]);
   endproperty
   a_prr: assert property (p_prr) else $error("peripheral gate wrong");

   property p_sleep_off;
      @(posedge clk) disable iff (rst)
         (!asleep && sleep_req && !ctrl_q[SMCG_CTRL_EN]) |=> !asleep;
   endproperty
   a_sleep_off: assert property (p_sleep_off) else $error("sleep while off");
   property p_bad_mode;
      @(posedge clk) disable iff (rst)
         (!asleep && sleep_req && !legal) |=> !asleep;
   endproperty
   a_bad_mode: assert property (p_bad_mode) else $error("bad mode slept");
   property p_sleep_enter;
      @(posedge clk) disable iff (rst)
         (!asleep && sleep_req && ctrl_q[SMCG_CTRL_EN] && legal) |=> asleep && !cpu_clk_en;
   endproperty
   a_sleep_enter: assert property (p_sleep_enter) else $error("sleep missed");
   property p_deep_periph;
      @(posedge clk) disable iff (rst)
         (asleep && mode_q != SMCG_IDLE) |-> !(|periph_clk_en);
   endproperty
   a_deep_periph: assert property (p_deep_periph) else $error("periph clock on");
   property p_idle_periph;
      @(posedge clk) disable iff (rst)
         (asleep && mode_q == SMCG_IDLE) |-> periph_clk_en == ~$past(prr_q[NPERIPH-1:0]);
   endproperty
   a_idle_periph: assert property (p_idle_periph) else $error("idle periph bad");
   property p_stby_nocnt;
      @(posedge clk) disable iff (rst)
         (asleep && mode_q == SMCG_STBY && !(|wvec[SMCG_W_PIN:SMCG_W_TWOWIRE])) |=> asleep;
   endproperty
   a_stby_nocnt: assert property (p_stby_nocnt) else $error("stby bad wake");
   property p_deep_noirq;
      @(posedge clk) disable iff (rst)
         (asleep && mode_q != SMCG_IDLE && !(|wvec[SMCG_W_CNT:SMCG_W_TWOWIRE])) |=> asleep;
   endproperty
   a_deep_noirq: assert property (p_deep_noirq) else $error("irq woke deep");
   property p_active_clks;
      @(posedge clk) disable iff (rst)
         !asleep |-> cpu_clk_en && sys_clk_en && osc_main_en && osc_xtal_en && rtc_clk_en;
   endproperty
   a_active_clks: assert property (p_active_clks) else $error("active gate off");
   property p_bus_wake;
      @(posedge clk) disable iff (rst)
         (asleep && (wake_two_wire_serial_port || wake_usb_resume)) |=> !asleep && cpu_clk_en;
   endproperty
   a_bus_wake: assert property (p_bus_wake) else $error("bus wake missed");
endmodule // smcg_top
`default_nettype wire
